// ===== aofs_top.sv
// Auxiliary output function select, display style, alarm reference and set-point choice
// Operation
// - Aux 1 full source list, default alarm 1
// - Aux 2 full source list, default alarm 2
// - Aux 3 limited list, default alarm 3
// - Cooling under standard control outputs zero
// - Work bits withheld without logic operation
// - Aux 3 program end inactive when pattern off
// - Character style on 11-seg, off 7-seg
// - Alarm reference present or segment set point
// - Reference applies only to deviation alarm types
// - Remote enable allows remote set point switching
// - Remote disabled uses program or fixed
`include "aofs_map.svh"
module aofs_top
    import aofs_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire aofs_cfg_t cfg_in,
    input wire aofs_sources_t src_in,
    input wire logic character_style_select_in,
    input wire logic alarm_reference_select_in,
    input wire logic cfg_misc_load_in,
    input wire logic [2:0] alarm_assigned_in,
    input wire logic [3:0] alarm_type_in,
    input wire logic ramp_segment_in,
    input wire logic remote_setpoint_enable_in,
    input wire logic present_setpoint_choice_in,
    input wire logic remote_request_in,
    output logic [2:0] aux_out,
    output logic [4:0] sel1_out,
    output logic [4:0] sel2_out,
    output logic [4:0] sel3_out,
    output logic eleven_segment_out,
    output logic segment_reference_out,
    output aofs_sp_t setpoint_source_out
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [4:0] sel1;
        logic [4:0] sel2;
        logic [4:0] sel3;
        logic char_style;
        logic alarm_ref;
        logic remote_en;
        logic [2:0] aux;
        logic seg_ref;
        aofs_sp_t sp;
    } aofs_state_t;

    aofs_state_t state_q;
    aofs_state_t state_d;
    // One routed level per auxiliary output, bit 0 for the first
    logic [2:0] route_level;

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    // Selector legality: an out-of-range code is refused and the old one kept.
    // Refusing rather than clamping keeps a bad write from silently retargeting an output.
    function automatic logic sel_legal(input logic [4:0] sel, input logic third, input logic logic_op);
        logic ok;
        ok = (sel < `AOFS_SRC_COUNT);
        if (third && sel >= 5'(AOFS_SRC_STAGE) && sel <= 5'(AOFS_SRC_TSIG2))
        begin
            ok = 1'b0;
        end
        if (!logic_op && sel >= 5'(AOFS_SRC_WORK1))
        begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // Deviation alarm types, the only ones a segment reference can apply to
    function automatic logic is_deviation_type(input logic [3:0] code);
        logic hit;
        hit = (code >= `AOFS_DEV_TYPE_MIN) && (code <= `AOFS_DEV_TYPE_MAX);
        return hit;
    endfunction

    // ----------------------------------------
    // Routing
    // ----------------------------------------
    aofs_route u_route1 (
        .sel_in(state_q.sel1),
        .full_list_in(1'b1),
        .is_third_in(1'b0),
        .src_in(src_in),
        .heat_cool_mode_in(cfg_in.heat_cool_mode),
        .logic_op_used_in(cfg_in.logic_op_used),
        .program_pattern_on_in(cfg_in.program_pattern_on),
        .level_out(route_level[0])
    );
    aofs_route u_route2 (
        .sel_in(state_q.sel2),
        .full_list_in(1'b1),
        .is_third_in(1'b0),
        .src_in(src_in),
        .heat_cool_mode_in(cfg_in.heat_cool_mode),
        .logic_op_used_in(cfg_in.logic_op_used),
        .program_pattern_on_in(cfg_in.program_pattern_on),
        .level_out(route_level[1])
    );
    // Third output offers no stage, run or time signals
    aofs_route u_route3 (
        .sel_in(state_q.sel3),
        .full_list_in(1'b0),
        .is_third_in(1'b1),
        .src_in(src_in),
        .heat_cool_mode_in(cfg_in.heat_cool_mode),
        .logic_op_used_in(cfg_in.logic_op_used),
        .program_pattern_on_in(cfg_in.program_pattern_on),
        .level_out(route_level[2])
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        logic dev_type;
        logic all_assigned;
        dev_type = is_deviation_type(alarm_type_in);
        all_assigned = &alarm_assigned_in;
        state_d = state_q;

        // ----------------------------------------
        // Selector loads
        // ----------------------------------------
        if (cfg_in.load)
        begin
            if (sel_legal(cfg_in.sel1, 1'b0, cfg_in.logic_op_used))
            begin
                state_d.sel1 = cfg_in.sel1;
            end
            if (sel_legal(cfg_in.sel2, 1'b0, cfg_in.logic_op_used))
            begin
                state_d.sel2 = cfg_in.sel2;
            end
            if (sel_legal(cfg_in.sel3, 1'b1, cfg_in.logic_op_used))
            begin
                state_d.sel3 = cfg_in.sel3;
            end
        end

        // ----------------------------------------
        // Display and set-point settings
        // ----------------------------------------
        if (cfg_misc_load_in)
        begin
            state_d.char_style = character_style_select_in;
            state_d.alarm_ref = alarm_reference_select_in;
            state_d.remote_en = remote_setpoint_enable_in;
        end

        // ----------------------------------------
        // Routed outputs
        // ----------------------------------------
        // Registered so a source glitch never reaches a relay driver mid-cycle
        state_d.aux = route_level;

        // ----------------------------------------
        // Alarm reference
        // ----------------------------------------
        // Segment reference only during ramps with deviation alarms on all three
        state_d.seg_ref = state_q.alarm_ref & ramp_segment_in & all_assigned & dev_type;

        // ----------------------------------------
        // Set-point source
        // ----------------------------------------
        // The request is a level; without the enable it is simply ignored
        if (state_q.remote_en && remote_request_in)
        begin
            state_d.sp = AOFS_SP_REMOTE;
        end
        else
        begin
            state_d.sp = present_setpoint_choice_in ? AOFS_SP_FIXED : AOFS_SP_PROGRAM;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // A mid-run reset restores the power-up selections and styles
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state_q.sel1 <= `AOFS_AUX1_DEFAULT;
            state_q.sel2 <= `AOFS_AUX2_DEFAULT;
            state_q.sel3 <= `AOFS_AUX3_DEFAULT;
            state_q.char_style <= `AOFS_CHAR_STYLE_DEFAULT;
            state_q.alarm_ref <= `AOFS_ALARM_REF_DEFAULT;
            state_q.remote_en <= `AOFS_REMOTE_EN_DEFAULT;
            state_q.aux <= 3'h0;
            state_q.seg_ref <= 1'b0;
            state_q.sp <= AOFS_SP_PROGRAM;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign aux_out = state_q.aux;
    assign sel1_out = state_q.sel1;
    assign sel2_out = state_q.sel2;
    assign sel3_out = state_q.sel3;
    assign eleven_segment_out = state_q.char_style;
    assign segment_reference_out = state_q.seg_ref;
    assign setpoint_source_out = state_q.sp;
endmodule // aofs_top

// ===== aofs_map.svh
// Constants for the auxiliary output function select block
`ifndef AOFS_MAP_SVH
`define AOFS_MAP_SVH
`define AOFS_SEL_W 5
`define AOFS_WORK_W 8
`define AOFS_SRC_COUNT 5'h14
`define AOFS_AUX1_DEFAULT 5'h03
`define AOFS_AUX2_DEFAULT 5'h04
`define AOFS_AUX3_DEFAULT 5'h05
`define AOFS_CHAR_STYLE_DEFAULT 1'b1
`define AOFS_ALARM_REF_DEFAULT 1'b0
`define AOFS_REMOTE_EN_DEFAULT 1'b0
`define AOFS_DEV_TYPE_MIN 4'h1
`define AOFS_DEV_TYPE_MAX 4'h7
`define AOFS_COOL_STD_LEVEL 1'b0
`endif

// ===== aofs_pkg.sv
// Types for the auxiliary output function select block
package aofs_pkg;
    // Source selector codes, shared by all three auxiliary outputs
    typedef enum logic [4:0] {
        AOFS_SRC_NONE = 5'h00,
        AOFS_SRC_HEAT = 5'h01,
        AOFS_SRC_COOL = 5'h02,
        AOFS_SRC_ALM1 = 5'h03,
        AOFS_SRC_ALM2 = 5'h04,
        AOFS_SRC_ALM3 = 5'h05,
        AOFS_SRC_PEND = 5'h06,
        AOFS_SRC_CNT_ALM = 5'h07,
        AOFS_SRC_STAGE = 5'h08,
        AOFS_SRC_RUN = 5'h09,
        AOFS_SRC_TSIG1 = 5'h0A,
        AOFS_SRC_TSIG2 = 5'h0B,
        AOFS_SRC_WORK1 = 5'h0C,
        AOFS_SRC_WORK2 = 5'h0D,
        AOFS_SRC_WORK3 = 5'h0E,
        AOFS_SRC_WORK4 = 5'h0F,
        AOFS_SRC_WORK5 = 5'h10,
        AOFS_SRC_WORK6 = 5'h11,
        AOFS_SRC_WORK7 = 5'h12,
        AOFS_SRC_WORK8 = 5'h13
    } aofs_src_t;

    // Set-point in use
    typedef enum logic [1:0] {
        AOFS_SP_PROGRAM = 2'h0,
        AOFS_SP_FIXED = 2'h1,
        AOFS_SP_REMOTE = 2'h3
    } aofs_sp_t;

    // Internal function levels that can be routed
    typedef struct packed {
        logic heat;
        logic cool;
        logic [2:0] alarm;
        logic program_end;
        logic switch_count_alarm_source;
        logic stage;
        logic run;
        logic [1:0] time_signal;
        logic [7:0] work_bit;
    } aofs_sources_t;

    // Configuration bits
    typedef struct packed {
        logic heat_cool_mode;
        logic logic_op_used;
        logic program_pattern_on;
        logic [4:0] sel1;
        logic [4:0] sel2;
        logic [4:0] sel3;
        logic load;
    } aofs_cfg_t;
endpackage

// ===== aofs_route.sv
// One auxiliary output source multiplexer (combinational)
`include "aofs_map.svh"
module aofs_route
    import aofs_pkg::*;
(
    input wire logic [4:0] sel_in,
    input wire logic full_list_in,
    input wire logic is_third_in,
    input wire aofs_sources_t src_in,
    input wire logic heat_cool_mode_in,
    input wire logic logic_op_used_in,
    input wire logic program_pattern_on_in,
    output logic level_out
);
    always_comb
    begin
        level_out = 1'b0;
        unique case (sel_in)
            AOFS_SRC_HEAT: level_out = src_in.heat;
            AOFS_SRC_COOL: level_out = heat_cool_mode_in ? src_in.cool : `AOFS_COOL_STD_LEVEL;
            AOFS_SRC_ALM1: level_out = src_in.alarm[0];
            AOFS_SRC_ALM2: level_out = src_in.alarm[1];
            AOFS_SRC_ALM3: level_out = src_in.alarm[2];
            AOFS_SRC_PEND: level_out = src_in.program_end & (program_pattern_on_in | ~is_third_in);
            AOFS_SRC_CNT_ALM: level_out = src_in.switch_count_alarm_source;
            AOFS_SRC_STAGE: level_out = full_list_in & src_in.stage;
            AOFS_SRC_RUN: level_out = full_list_in & src_in.run;
            AOFS_SRC_TSIG1: level_out = full_list_in & src_in.time_signal[0];
            AOFS_SRC_TSIG2: level_out = full_list_in & src_in.time_signal[1];
            AOFS_SRC_WORK1, AOFS_SRC_WORK2, AOFS_SRC_WORK3, AOFS_SRC_WORK4,
            AOFS_SRC_WORK5, AOFS_SRC_WORK6, AOFS_SRC_WORK7, AOFS_SRC_WORK8:
                level_out = logic_op_used_in & src_in.work_bit[3'(sel_in - 5'(AOFS_SRC_WORK1))];
            default: level_out = 1'b0;
        endcase
    end
endmodule // aofs_route

// ===== aofs_top_assertions.sv
// Assertion checker for the auxiliary output function select block
module aofs_checker
    import aofs_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire aofs_cfg_t cfg_in,
    input wire aofs_sources_t src_in,
    input wire logic [2:0] alarm_assigned_in,
    input wire logic [3:0] alarm_type_in,
    input wire logic ramp_segment_in,
    input wire logic present_setpoint_choice_in,
    input wire logic remote_request_in,
    input wire logic [2:0] aux_out,
    input wire logic [4:0] sel1_out,
    input wire logic [4:0] sel2_out,
    input wire logic [4:0] sel3_out,
    input wire logic eleven_segment_out,
    input wire logic segment_reference_out,
    input wire aofs_sp_t setpoint_source_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_heat_load;
        cfg_in.load && cfg_in.sel1 == 5'h01;
    endsequence
    AST_SEL_RST: assert property ($past(srst_in) |-> sel1_out == 5'h03 && sel2_out == 5'h04
        && sel3_out == 5'h05) else $error("Selector reset value wrong");
    AST_STYLE_RST: assert property ($past(srst_in) |-> eleven_segment_out) else $error("Style reset wrong");
    AST_WALK: assert property (s_heat_load |-> ##1 sel1_out == 5'h01 ##1 aux_out[0] == $past(src_in.heat))
        else $error("Heat routing late or wrong");
    AST_NONE: assert property (sel1_out == 5'h00 |=> !aux_out[0]) else $error("None not inactive");
    AST_COOL: assert property (sel2_out == 5'h02 && !cfg_in.heat_cool_mode |=> !aux_out[1])
        else $error("Cooling not zero");
    AST_WORK: assert property (sel1_out >= 5'h0C && !cfg_in.logic_op_used |=> !aux_out[0])
        else $error("Work bit leaked");
    AST_PEND: assert property (sel3_out == 5'h06 && !cfg_in.program_pattern_on |=> !aux_out[2])
        else $error("Program end leaked");
    AST_AUX3_LIST: assert property (cfg_in.load && cfg_in.sel3 inside {[5'h08:5'h0B]} |=> $stable(sel3_out))
        else $error("Third selector took a barred code");
    AST_SEL2_LOAD: assert property (cfg_in.load && cfg_in.sel2 < 5'h0C |=> sel2_out == $past(cfg_in.sel2))
        else $error("Second selector not loaded");
    AST_SEG_REF: assert property (segment_reference_out |-> $past(ramp_segment_in) && $past(alarm_assigned_in) == 3'h7
        && $past(alarm_type_in) inside {[4'h1:4'h7]}) else $error("Segment reference without cause");
    AST_REMOTE: assert property (setpoint_source_out == AOFS_SP_REMOTE |-> $past(remote_request_in))
        else $error("Remote without request");
    AST_LOCAL: assert property (!$past(srst_in) && !$past(remote_request_in) |-> setpoint_source_out ==
        ($past(present_setpoint_choice_in) ? AOFS_SP_FIXED : AOFS_SP_PROGRAM)) else $error("Local set point wrong");
endmodule // aofs_checker
bind aofs_top aofs_checker aofs_checker_i (.*);

// ===== aofs_relay_model.sv
// Relay driver model at the far side of the auxiliary outputs
module aofs_relay_model
(
    input wire logic clk_in,
    input wire logic [2:0] drive_in,
    output logic [2:0] relay_on_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Driver stage latches the level, so contacts lag the drive by a clock
    always_ff @(posedge clk_in)
    begin
        relay_on_out <= drive_in;
    end
endmodule // aofs_relay_model

// ===== aofs_top_tb.sv
// Self-checking testbench for the auxiliary output function select block
module aofs_top_tb import aofs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0, srst_in = 1'b1, character_style_select_in = 1'b1, alarm_reference_select_in = 1'b0;
    logic cfg_misc_load_in = 1'b0, ramp_segment_in = 1'b1, remote_setpoint_enable_in = 1'b0;
    logic present_setpoint_choice_in = 1'b0, remote_request_in = 1'b0, eleven_segment_out, segment_reference_out;
    aofs_cfg_t cfg_in = '0;
    aofs_sources_t src_in = '0;
    logic [2:0] alarm_assigned_in = 3'h7, aux_out, relay_on;
    logic [3:0] alarm_type_in = 4'h1;
    logic [4:0] sel1_out, sel2_out, sel3_out;
    aofs_sp_t setpoint_source_out;
    int fail_count = 0, num_checks = 0, e3 = 5;
    aofs_top aofs_top_i (.*);
    aofs_relay_model aofs_relay_model_i (.clk_in(clk_in), .drive_in(aux_out), .relay_on_out(relay_on));
    always #5 clk_in = ~clk_in;
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Routed output appears two edges after the load
    task automatic sel(input logic [4:0] a, b, c);
        cfg_in.sel1 = a;
        cfg_in.sel2 = b;
        cfg_in.sel3 = c;
        cfg_in.load = 1'b1;
        step(1);
        cfg_in.load = 1'b0;
        step(1);
    endtask
    task automatic misc(input logic c, r, e);
        character_style_select_in = c;
        alarm_reference_select_in = r;
        remote_setpoint_enable_in = e;
        cfg_misc_load_in = 1'b1;
        step(1);
        cfg_misc_load_in = 1'b0;
        step(1);
    endtask
    function automatic logic lvl(input logic [4:0] c, input logic is3);
        case (c)
            5'h00: return 1'b0;
            5'h01: return src_in.heat;
            5'h02: return src_in.cool & cfg_in.heat_cool_mode;
            5'h03, 5'h04, 5'h05: return src_in.alarm[c - 5'h03];
            5'h06: return src_in.program_end & (cfg_in.program_pattern_on | ~is3);
            5'h07: return src_in.switch_count_alarm_source;
            5'h08: return src_in.stage;
            5'h09: return src_in.run;
            5'h0A, 5'h0B: return src_in.time_signal[c - 5'h0A];
            default: return src_in.work_bit[c - 5'h0C] & cfg_in.logic_op_used;
        endcase
    endfunction
    initial
    begin
        step(8);
        srst_in = 1'b0;
        step(1);
        chk(sel1_out, 5'h03);
        chk(sel2_out, 5'h04);
        chk(sel3_out, 5'h05);
        chk(eleven_segment_out, 1'b1);
        cfg_in.logic_op_used = 1'b1;
        cfg_in.heat_cool_mode = 1'b1;
        cfg_in.program_pattern_on = 1'b1;
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 20; c++)
            begin
                src_in = p ? 19'h2_5A3C : 19'h5_A5C3;
                if (c < 8 || c > 11)
                    e3 = c;
                sel(c[4:0], c[4:0], c[4:0]);
                chk(sel1_out, c[4:0]);
                chk(sel2_out, c[4:0]);
                chk(sel3_out, e3[4:0]);
                chk(aux_out, {lvl(e3[4:0], 1'b1), lvl(c[4:0], 1'b0), lvl(c[4:0], 1'b0)});
            end
        sel(5'h14, 5'h14, 5'h14);
        chk(sel1_out, 5'h13);
        src_in = '1;
        cfg_in.logic_op_used = 1'b0;
        step(1);
        chk(aux_out, 3'h0);
        cfg_in.heat_cool_mode = 1'b0;
        cfg_in.program_pattern_on = 1'b0;
        sel(5'h0C, 5'h02, 5'h06);
        chk(sel1_out, 5'h13);
        chk(aux_out, 3'h0);
        cfg_in.heat_cool_mode = 1'b1;
        cfg_in.program_pattern_on = 1'b1;
        step(1);
        chk(aux_out, 3'h6);
        step(1);
        chk(relay_on, 3'h6);
        misc(1'b0, 1'b1, 1'b0);
        chk(eleven_segment_out, 1'b0);
        for (int t = 0; t < 9; t++)
        begin
            alarm_type_in = t[3:0];
            step(1);
            chk(segment_reference_out, t inside {[1:7]});
        end
        alarm_type_in = 4'h2;
        alarm_assigned_in = 3'h3;
        step(1);
        chk(segment_reference_out, 1'b0);
        alarm_assigned_in = 3'h7;
        ramp_segment_in = 1'b0;
        step(1);
        chk(segment_reference_out, 1'b0);
        ramp_segment_in = 1'b1;
        misc(1'b1, 1'b0, 1'b1);
        chk(segment_reference_out, 1'b0);
        remote_request_in = 1'b1;
        step(1);
        chk(setpoint_source_out, AOFS_SP_REMOTE);
        remote_request_in = 1'b0;
        present_setpoint_choice_in = 1'b1;
        step(1);
        chk(setpoint_source_out, AOFS_SP_FIXED);
        misc(1'b1, 1'b0, 1'b0);
        remote_request_in = 1'b1;
        step(1);
        chk(setpoint_source_out, AOFS_SP_FIXED);
        misc(1'b0, 1'b1, 1'b1);
        srst_in = 1'b1;
        step(1);
        srst_in = 1'b0;
        step(1);
        chk(sel1_out, 5'h03);
        chk(eleven_segment_out, 1'b1);
        chk(segment_reference_out, 1'b0);
        chk(setpoint_source_out, AOFS_SP_FIXED);
        close_out();
    end
    initial
    begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule // aofs_top_tb
